// *** mbrtu_write_slave.sv ***
// serial register-write slave: 8N1 receiver, frame checker, write sequencer, responder
// assumes I_RXD idles high and the master keeps the line quiet while we answer
module mbrtu_write_slave #(
    parameter int unsigned CLK_HZ = mbrtu_pkg::CLK_HZ_DEF,
    parameter int unsigned DEPTH  = 256,
    parameter int unsigned AW     = 8
) (
    input  wire logic        I_CLK,
    input  wire logic        I_NRST,
    input  wire logic        I_RXD,
    input  wire logic [1:0]  I_BAUD_SEL,
    input  wire logic [7:0]  I_STATION_ADDR,
    input  wire logic        I_WR_FAIL,
    output logic             O_TXD,
    output logic             O_TX_EN,
    output logic             O_WR_STB,
    output logic [15:0]      O_WR_OBJ,
    output logic [15:0]      O_WR_DATA
);
    typedef enum logic [2:0] {
        S_RECV, S_CHECK, S_FETCH_H, S_FETCH_L, S_PUT, S_ACK, S_TX_LOAD, S_TX_SHIFT
    } state_type;

    // clock cycles per bit for a rate selection
    function automatic logic [23:0] bit_cycles(input logic [1:0] sel);
        int unsigned baud;
        case (sel)
            2'd0:    baud = mbrtu_pkg::BAUD_9600;
            2'd1:    baud = mbrtu_pkg::BAUD_19200;
            2'd2:    baud = mbrtu_pkg::BAUD_38400;
            default: baud = mbrtu_pkg::BAUD_57600;
        endcase
        return 24'(CLK_HZ / baud);
    endfunction : bit_cycles

    // one byte into the reflected check register
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ mbrtu_pkg::CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_byte

    ////////////////////////////////////////////////////////////////////////////
    // timing
    wire logic [23:0] bit_len  = bit_cycles(I_BAUD_SEL);
    wire logic [23:0] half_len = {1'b0, bit_len[23:1]};
    wire logic [23:0] gap_len  = 24'(bit_len * mbrtu_pkg::GAP_BITS);

    ////////////////////////////////////////////////////////////////////////////
    // receiver state
    state_type   state_reg;
    logic        rx_act_reg;
    logic [3:0]  rx_bit_reg;
    logic [23:0] rx_cnt_reg;
    logic [7:0]  rx_sh_reg;
    logic [23:0] quiet_reg;
    logic [8:0]  rx_len_reg;
    logic [15:0] rx_crc_reg;
    logic        rx_err_reg;
    logic [7:0]  hdr_reg [0:mbrtu_pkg::HDR_BYTES-1];
    // sequencer and transmitter state
    logic [AW-1:0] rd_idx_reg;
    logic [7:0]  hi_reg;
    logic [15:0] left_reg;
    logic        exc_reg;
    logic [7:0]  code_reg;
    logic [2:0]  tx_idx_reg;
    logic [9:0]  tx_sh_reg;
    logic [3:0]  tx_bit_reg;
    logic [23:0] tx_cnt_reg;
    logic [15:0] tx_crc_reg;
    logic [7:0]  rdata;

    // 8N1 framing: start, eight data bits LSB first, stop
    wire logic rx_tick   = rx_act_reg && (rx_cnt_reg == 24'd0);
    wire logic rx_done   = rx_tick && (rx_bit_reg == 4'(mbrtu_pkg::DATA_BITS + 1));
    wire logic byte_in   = rx_done && (state_reg == S_RECV);
    wire logic frame_end = (quiet_reg == gap_len) && (rx_len_reg != 9'd0);
    wire logic mem_we    = byte_in && (rx_len_reg < 9'(DEPTH));

    ////////////////////////////////////////////////////////////////////////////
    // bit sampler: start edge, then sample mid-bit
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rx_act_reg <= 1'b0;
            rx_bit_reg <= 4'd0;
            rx_cnt_reg <= 24'd0;
            rx_sh_reg  <= 8'h00;
        end else if (!rx_act_reg) begin
            rx_act_reg <= !I_RXD;
            rx_bit_reg <= 4'd0;
            rx_cnt_reg <= half_len;
        end else if (rx_tick) begin
            rx_cnt_reg <= bit_len - 24'd1;
            rx_bit_reg <= rx_bit_reg + 4'd1;
            if (rx_bit_reg == 4'd0 && I_RXD) begin
                rx_act_reg <= 1'b0; // glitch, not a start bit
            end else if (rx_bit_reg == 4'(mbrtu_pkg::DATA_BITS + 1)) begin
                rx_act_reg <= 1'b0;
            end else if (rx_bit_reg != 4'd0) begin
                rx_sh_reg <= {I_RXD, rx_sh_reg[7:1]};
            end
        end else begin
            rx_cnt_reg <= rx_cnt_reg - 24'd1;
        end
    end

    // line silence counter, saturates one past the gap
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            quiet_reg <= 24'd0;
        end else if (rx_act_reg || !I_RXD) begin
            quiet_reg <= 24'd0;
        end else if (quiet_reg <= gap_len) begin
            quiet_reg <= quiet_reg + 24'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame decode from captured header bytes, the running check and the byte count
    wire logic [7:0]  fn       = hdr_reg[1];
    wire logic [15:0] reg_cnt  = {hdr_reg[4], hdr_reg[5]};
    wire logic [7:0]  byte_cnt = hdr_reg[6];
    wire logic addr_ok  = (hdr_reg[0] == I_STATION_ADDR) && (I_STATION_ADDR >= mbrtu_pkg::STATION_MIN)
                          && (I_STATION_ADDR <= mbrtu_pkg::STATION_MAX);
    wire logic crc_ok   = (rx_crc_reg == mbrtu_pkg::CRC_RESID) && !rx_err_reg
                          && (rx_len_reg >= 9'(mbrtu_pkg::MIN_FRAME));
    wire logic cnt_ok   = (reg_cnt != 16'h0000) && (reg_cnt[15:7] == 9'd0)
                          && ({reg_cnt[6:0], 1'b0} == byte_cnt);
    wire logic many_ok  = cnt_ok && (rx_len_reg == 9'(byte_cnt) + 9'(mbrtu_pkg::LEN_MANY_X));
    wire logic one_ok   = (rx_len_reg == 9'(mbrtu_pkg::LEN_WR_ONE));

    // response bytes: header echo or exception, then check low, check high
    wire logic [2:0] pay_len = exc_reg ? 3'(mbrtu_pkg::PAY_EXC) : 3'(mbrtu_pkg::PAY_NORMAL);
    wire logic [7:0] pay_byte = (exc_reg && tx_idx_reg == 3'd1) ? (fn + mbrtu_pkg::FN_EXC_FLAG)
                              : (exc_reg && tx_idx_reg == 3'd2) ? code_reg
                              : hdr_reg[tx_idx_reg];
    wire logic [7:0] tx_byte = (tx_idx_reg < pay_len) ? pay_byte
                             : (tx_idx_reg == pay_len) ? tx_crc_reg[7:0] : tx_crc_reg[15:8];
    wire logic tx_tick = (tx_cnt_reg == 24'd0);
    wire logic [15:0] put_data = (fn == mbrtu_pkg::FN_WR_ONE) ? {hdr_reg[4], hdr_reg[5]} : {hi_reg, rdata};

    ////////////////////////////////////////////////////////////////////////////
    // frame collection and check accumulation
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rx_len_reg <= 9'd0;
            rx_crc_reg <= mbrtu_pkg::CRC_INIT;
            rx_err_reg <= 1'b0;
            for (int i = 0; i < mbrtu_pkg::HDR_BYTES; i++) begin
                hdr_reg[i] <= 8'h00;
            end
        end else if (state_reg == S_CHECK) begin
            rx_len_reg <= 9'd0;
            rx_crc_reg <= mbrtu_pkg::CRC_INIT;
            rx_err_reg <= 1'b0;
        end else if (byte_in) begin
            rx_crc_reg <= crc_byte(rx_crc_reg, rx_sh_reg);
            rx_err_reg <= rx_err_reg || !I_RXD || (rx_len_reg >= 9'(DEPTH)); // framing or overlong
            if (rx_len_reg < 9'(DEPTH)) begin
                rx_len_reg <= rx_len_reg + 9'd1;
            end
            if (rx_len_reg < 9'(mbrtu_pkg::HDR_BYTES)) begin
                hdr_reg[rx_len_reg[2:0]] <= rx_sh_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequencer: check, write registers, answer
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            state_reg  <= S_RECV;
            rd_idx_reg <= '0;
            hi_reg     <= 8'h00;
            left_reg   <= 16'h0000;
            exc_reg    <= 1'b0;
            code_reg   <= 8'h00;
            tx_idx_reg <= 3'd0;
            tx_sh_reg  <= 10'h3FF;
            tx_bit_reg <= 4'd0;
            tx_cnt_reg <= 24'd0;
            tx_crc_reg <= mbrtu_pkg::CRC_INIT;
            O_WR_STB   <= 1'b0;
            O_WR_OBJ   <= 16'h0000;
            O_WR_DATA  <= 16'h0000;
            O_TXD      <= 1'b1;
            O_TX_EN    <= 1'b0;
        end else begin
            O_TXD   <= (state_reg == S_TX_SHIFT) ? tx_sh_reg[0] : 1'b1;
            O_TX_EN <= (state_reg == S_TX_SHIFT);
            case (state_reg)
                S_RECV: begin
                    exc_reg    <= 1'b0;
                    tx_idx_reg <= 3'd0;
                    tx_crc_reg <= mbrtu_pkg::CRC_INIT;
                    if (frame_end) begin
                        state_reg <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    O_WR_OBJ   <= {hdr_reg[2], hdr_reg[3]};
                    rd_idx_reg <= AW'(mbrtu_pkg::DATA_START);
                    left_reg   <= reg_cnt;
                    code_reg   <= mbrtu_pkg::ERR_VALUE;
                    if (!crc_ok || !addr_ok) begin
                        state_reg <= S_RECV;
                    end else if (fn == mbrtu_pkg::FN_WR_ONE) begin
                        left_reg  <= 16'h0001;
                        exc_reg   <= !one_ok;
                        state_reg <= one_ok ? S_PUT : S_TX_LOAD;
                    end else if (fn == mbrtu_pkg::FN_WR_MANY) begin
                        exc_reg   <= !many_ok;
                        state_reg <= many_ok ? S_FETCH_H : S_TX_LOAD;
                    end else begin
                        exc_reg   <= 1'b1;
                        code_reg  <= (fn == mbrtu_pkg::FN_READ) ? mbrtu_pkg::ERR_ADDR : mbrtu_pkg::ERR_FUNC;
                        state_reg <= S_TX_LOAD;
                    end
                end
                S_FETCH_H: begin
                    rd_idx_reg <= rd_idx_reg + AW'(1);
                    state_reg  <= S_FETCH_L;
                end
                S_FETCH_L: begin
                    hi_reg     <= rdata;
                    rd_idx_reg <= rd_idx_reg + AW'(1);
                    state_reg  <= S_PUT;
                end
                S_PUT: begin
                    O_WR_STB  <= 1'b1;
                    O_WR_DATA <= put_data;
                    left_reg  <= left_reg - 16'h0001;
                    state_reg <= S_ACK;
                end
                S_ACK: begin
                    // fail is sampled while the strobe is high
                    O_WR_STB <= 1'b0;
                    if (I_WR_FAIL) begin
                        exc_reg   <= 1'b1;
                        code_reg  <= mbrtu_pkg::ERR_DEVICE;
                        state_reg <= S_TX_LOAD;
                    end else if (left_reg == 16'h0000) begin
                        state_reg <= S_TX_LOAD;
                    end else begin
                        O_WR_OBJ  <= O_WR_OBJ + 16'h0001;
                        state_reg <= S_FETCH_H;
                    end
                end
                S_TX_LOAD: begin
                    tx_sh_reg  <= {1'b1, tx_byte, 1'b0};
                    tx_bit_reg <= 4'd0;
                    tx_cnt_reg <= bit_len - 24'd1;
                    if (tx_idx_reg < pay_len) begin
                        tx_crc_reg <= crc_byte(tx_crc_reg, tx_byte);
                    end
                    state_reg <= S_TX_SHIFT;
                end
                S_TX_SHIFT: begin
                    tx_cnt_reg <= tx_tick ? bit_len - 24'd1 : tx_cnt_reg - 24'd1;
                    if (tx_tick && tx_bit_reg == 4'(mbrtu_pkg::CHAR_BITS - 1)) begin
                        tx_idx_reg <= tx_idx_reg + 3'd1;
                        state_reg  <= (tx_idx_reg == pay_len + 3'd1) ? S_RECV : S_TX_LOAD;
                    end else if (tx_tick) begin
                        tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
                        tx_bit_reg <= tx_bit_reg + 4'd1;
                    end
                end
                default: begin
                    state_reg <= S_RECV;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame store; only written while collecting, so reads later are stable
    mbrtu_byte_store #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_store (
        .I_CLK   (I_CLK),
        .I_NRST  (I_NRST),
        .i_we    (mem_we),
        .i_waddr (rx_len_reg[AW-1:0]),
        .i_wdata (rx_sh_reg),
        .i_raddr (rd_idx_reg),
        .o_rdata (rdata)
    );
endmodule : mbrtu_write_slave

// *** mbrtu_pkg.sv ***
// constants shared by the serial register-write slave, its checks, master model and bench
// assumes a 100 MHz system clock unless the top module parameter says otherwise
package mbrtu_pkg;
    // line rates selected by the two-bit rate input
    localparam int unsigned BAUD_9600   = 9600;
    localparam int unsigned BAUD_19200  = 19200;
    localparam int unsigned BAUD_38400  = 38400;
    localparam int unsigned BAUD_57600  = 57600;
    localparam int unsigned CLK_HZ_DEF  = 100_000_000;
    // one character is start + 8 data + stop
    localparam int unsigned CHAR_BITS   = 10;
    localparam int unsigned DATA_BITS   = 8;
    // inter-frame silence in tenths of a character: 3.5 characters
    localparam int unsigned GAP_TENTHS  = 35;
    localparam int unsigned GAP_BITS    = GAP_TENTHS * CHAR_BITS / 10;
    // station address window
    localparam logic [7:0]  STATION_MIN = 8'h01;
    localparam logic [7:0]  STATION_MAX = 8'h20;
    // function codes
    localparam logic [7:0]  FN_READ     = 8'h03;
    localparam logic [7:0]  FN_WR_ONE   = 8'h06;
    localparam logic [7:0]  FN_WR_MANY  = 8'h10;
    localparam logic [7:0]  FN_EXC_FLAG = 8'h80;
    // exception codes
    localparam logic [7:0]  ERR_FUNC    = 8'h01;
    localparam logic [7:0]  ERR_ADDR    = 8'h02;
    localparam logic [7:0]  ERR_VALUE   = 8'h03;
    localparam logic [7:0]  ERR_DEVICE  = 8'h04;
    // frame geometry
    localparam int unsigned HDR_BYTES   = 7;
    localparam int unsigned LEN_WR_ONE  = 8;
    localparam int unsigned LEN_MANY_X  = 9;
    localparam int unsigned MIN_FRAME   = 4;
    localparam int unsigned PAY_NORMAL  = 6;
    localparam int unsigned PAY_EXC     = 3;
    localparam int unsigned DATA_START  = 7;
    // check field: reflected polynomial, all-ones start
    localparam logic [15:0] CRC_INIT    = 16'hFFFF;
    localparam logic [15:0] CRC_POLY    = 16'hA001;
    localparam logic [15:0] CRC_RESID   = 16'h0000;
endpackage : mbrtu_pkg

// *** mbrtu_byte_store.sv ***
// byte memory holding one received query frame
// assumes one writer and one reader in the same clock domain
module mbrtu_byte_store #(
    parameter int unsigned DEPTH = 256,
    parameter int unsigned AW    = 8
) (
    input  wire logic          I_CLK,
    input  wire logic          I_NRST,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [7:0]    i_wdata,
    input  wire logic [AW-1:0] i_raddr,
    output logic      [7:0]    o_rdata
);
    logic [7:0] mem [0:DEPTH-1];

    // array has no reset: contents are only read after being written
    always_ff @(posedge I_CLK) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // registered read, one cycle latency
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule : mbrtu_byte_store

// *** mbrtu_write_slave_asserts.sv ***
// port-level checks for the serial register-write slave
// assumes one clock domain and a bind from the bench with matching CLK_HZ
module mbrtu_write_slave_asserts #(
    parameter int unsigned CLK_HZ = 100_000_000
) (
    input wire logic        I_CLK,
    input wire logic        I_NRST,
    input wire logic        I_RXD,
    input wire logic [1:0]  I_BAUD_SEL,
    input wire logic [7:0]  I_STATION_ADDR,
    input wire logic        I_WR_FAIL,
    input wire logic        O_TXD,
    input wire logic        O_TX_EN,
    input wire logic        O_WR_STB,
    input wire logic [15:0] O_WR_OBJ,
    input wire logic [15:0] O_WR_DATA
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] bit_len;
    logic [31:0] gap_cyc;
    logic [23:0] quiet_reg;
    logic [23:0] quiet_next;
    ////////////////////////////////////////////////////////////
    // rate figures; the rate only changes between frames
    assign bit_len = (I_BAUD_SEL == 2'h0) ? CLK_HZ / mbrtu_pkg::BAUD_9600 :
                     (I_BAUD_SEL == 2'h1) ? CLK_HZ / mbrtu_pkg::BAUD_19200 :
                     (I_BAUD_SEL == 2'h2) ? CLK_HZ / mbrtu_pkg::BAUD_38400 : CLK_HZ / mbrtu_pkg::BAUD_57600;
    assign gap_cyc = mbrtu_pkg::GAP_BITS * bit_len;
    // receive-line silence, saturating so long pauses never wrap
    assign quiet_next = !I_RXD ? 24'h00_0000 : (quiet_reg == 24'hFF_FFFF) ? quiet_reg : quiet_reg + 24'h00_0001;
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            quiet_reg <= 24'h00_0000;
        end else begin
            quiet_reg <= quiet_next;
        end
    end
    ////////////////////////////////////////////////////////////
    // all checks share the system clock and reset
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    sequence start_bit_s;
        !O_TXD[*3];
    endsequence
    a_reset_idle: assert property ($rose(I_NRST) |-> O_TXD && !O_TX_EN && !O_WR_STB && O_WR_OBJ == 16'h0000)
        else $error("outputs not idle after reset");
    a_idle_high: assert property (!O_TX_EN |-> O_TXD)
        else $error("transmit line low while driver off");
    a_start_bit: assert property ($rose(O_TX_EN) |-> start_bit_s)
        else $error("character does not open with a start bit");
    a_char_hold: assert property ($rose(O_TX_EN) |-> O_TX_EN[*8])
        else $error("driver enable dropped inside a character");
    // the driver drops for a single load cycle between characters, so check the stop level around the drop
    a_load_gap: assert property ($fell(O_TX_EN) |-> O_TXD && $past(O_TXD))
        else $error("character ended without a stop level");
    a_answer_gap: assert property ($rose(O_TX_EN) |-> quiet_reg >= gap_cyc)
        else $error("answer began before the inter-frame silence");
    a_stb_pulse: assert property (O_WR_STB |=> !O_WR_STB)
        else $error("write strobe longer than one cycle");
    a_stb_to_tx: assert property (O_WR_STB |-> ##[3:6] (O_TX_EN || O_WR_STB))
        else $error("no answer or next write after a strobe");
    a_stb_silent: assert property (O_WR_STB |-> !O_TX_EN && quiet_reg >= gap_cyc)
        else $error("write strobe before the query ended");
endmodule : mbrtu_write_slave_asserts

// *** mbrtu_master_model.sv ***
// behavioural bus master on the serial line: sends query bytes, collects answer bytes
// assumes its tasks are called from the falling clock edge
module mbrtu_master_model #(
    parameter int unsigned CLK_HZ = 192_000
) (
    input  wire logic       i_clk,
    input  wire logic [1:0] i_baud_sel,
    input  wire logic       i_txd,
    output logic            o_rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned bl;
    // cycles per bit, rounded down like the slave
    assign bl = CLK_HZ / ((i_baud_sel == 2'h0) ? mbrtu_pkg::BAUD_9600 : (i_baud_sel == 2'h1) ?
                mbrtu_pkg::BAUD_19200 : (i_baud_sel == 2'h2) ? mbrtu_pkg::BAUD_38400 : mbrtu_pkg::BAUD_57600);
    // line idles high between characters and frames
    initial o_rxd = 1'b1;
    ////////////////////////////////////////////////////////////
    // one 8N1 character, least significant bit first
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] sh;
        sh = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_rxd = sh[i];
            repeat (bl) @(negedge i_clk);
        end
    endtask : send_byte
    // waits a bounded time for a start bit, samples mid-bit; ok low on timeout or bad stop
    task automatic recv_byte(input int unsigned lim, output logic [7:0] b, output logic ok);
        int unsigned n;
        n = 0;
        ok = 1'b0;
        b = 8'h00;
        while (i_txd !== 1'b0 && n < lim) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= lim) return;
        repeat (bl / 2) @(negedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bl) @(negedge i_clk);
            b[i] = i_txd;
        end
        repeat (bl) @(negedge i_clk);
        ok = (i_txd === 1'b1);
    endtask : recv_byte
endmodule : mbrtu_master_model

// *** tb.sv ***
// self-checking bench: the master model sends queries, answers and strobes are compared
// assumes a short CLK_HZ so every rate is a few cycles per bit
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef logic [7:0] bytes_type [$];
    localparam int unsigned CLK_HZ = 192_000;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        rxd;
    logic [1:0]  baud_sel = 2'h0;
    logic [7:0]  station = 8'h01;
    logic        wr_fail = 1'b0;
    logic        txd;
    logic        tx_en;
    logic        wr_stb;
    logic [15:0] wr_obj;
    logic [15:0] wr_data;
    int          err_total = 0;
    int          n_checks = 0;
    logic [31:0] stb_seen [$];
    logic [31:0] stb_exp [$];
    always #5 clk = ~clk;
    mbrtu_write_slave #(.CLK_HZ(CLK_HZ)) uut (.I_CLK(clk), .I_NRST(nrst), .I_RXD(rxd), .I_BAUD_SEL(baud_sel),
        .I_STATION_ADDR(station), .I_WR_FAIL(wr_fail), .O_TXD(txd), .O_TX_EN(tx_en), .O_WR_STB(wr_stb),
        .O_WR_OBJ(wr_obj), .O_WR_DATA(wr_data));
    mbrtu_master_model #(.CLK_HZ(CLK_HZ)) mst (.i_clk(clk), .i_baud_sel(baud_sel), .i_txd(txd), .o_rxd(rxd));
    // record every write shown by the slave
    // taken mid-cycle so the strobe and its object and data have settled
    always @(negedge clk) if (wr_stb === 1'b1) stb_seen.push_back({wr_obj, wr_data});
    ////////////////////////////////////////////////////////////
    // reflected 16-bit check field, all-ones start
    function automatic logic [15:0] crc16(input bytes_type f);
        logic [15:0] c;
        c = mbrtu_pkg::CRC_INIT;
        foreach (f[i]) begin
            c = c ^ {8'h00, f[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ mbrtu_pkg::CRC_POLY : c >> 1;
        end
        return c;
    endfunction : crc16
    // appends the check field, low byte first
    function automatic bytes_type seal(input bytes_type f);
        logic [15:0] c;
        c = crc16(f);
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        return f;
    endfunction : seal
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one query out, then the whole answer (or silence) and the strobes compared
    task automatic run(input bytes_type q, input bytes_type e);
        logic [7:0] b;
        logic       ok;
        stb_seen.delete();
        foreach (q[i]) mst.send_byte(q[i]);
        if (e.size() == 0) begin
            mst.recv_byte(60 * mst.bl, b, ok);
            check("answer", 32'h0000_0000, {31'h0000_0000, ok});
        end
        foreach (e[i]) begin
            mst.recv_byte(60 * mst.bl, b, ok);
            check("resp_byte", {23'h00_0000, 1'b1, e[i]}, {23'h00_0000, ok, b});
        end
        check("stb_count", stb_exp.size(), stb_seen.size());
        foreach (stb_exp[i]) check("stb", stb_exp[i], stb_seen[i]);
        repeat (2 * mst.bl) @(negedge clk);
    endtask : run
    task automatic end_sim();
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////
    // hang guard, well beyond the longest expected run
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        end_sim();
    end
    initial begin
        bytes_type   q;
        bytes_type   e;
        logic [31:0] r;
        logic [15:0] d;
        logic [7:0]  fn;
        int unsigned n;
        void'($urandom(32'hd366_829e));
        station = 8'(1 + $urandom % 32);
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        // single writes at every rate, echoed whole
        for (int s = 0; s < 4; s++) begin
            baud_sel = 2'(s);
            r = $urandom;
            q = {station, mbrtu_pkg::FN_WR_ONE, r[31:24], r[23:16], r[15:8], r[7:0]};
            stb_exp = {r};
            run(seal(q), seal(q));
        end
        // multiple writes: one strobe per register, objects counting up
        baud_sel = 2'h1;
        for (n = 1; n < 5; n++) begin
            r = $urandom;
            q = {station, mbrtu_pkg::FN_WR_MANY, r[31:24], r[23:16], 8'h00, 8'(n)};
            e = seal(q);
            q.push_back(8'(2 * n));
            stb_exp.delete();
            for (int i = 0; i < n; i++) begin
                d = r[15:0] + 16'(i);
                q.push_back(d[15:8]);
                q.push_back(d[7:0]);
                stb_exp.push_back({r[31:16] + 16'(i), d});
            end
            run(seal(q), e);
        end
        // malformed multiple writes: zero count, then byte count not twice the count
        stb_exp.delete();
        for (n = 0; n < 2; n++) begin
            q = {station, mbrtu_pkg::FN_WR_MANY, 8'h00, 8'h10, 8'h00, 8'(2 * n), 8'(3 * n)};
            repeat (3 * n) q.push_back(8'h5A);
            e = {station, 8'h90, mbrtu_pkg::ERR_VALUE};
            run(seal(q), seal(e));
        end
        // reads and unknown functions refused with function plus 128
        for (n = 0; n < 2; n++) begin
            fn = (n == 1) ? 8'h05 : mbrtu_pkg::FN_READ;
            q = {station, fn, 8'h00, 8'h01, 8'h00, 8'h01};
            e = {station, fn + 8'h80, (n == 1) ? mbrtu_pkg::ERR_FUNC : mbrtu_pkg::ERR_ADDR};
            run(seal(q), seal(e));
        end
        // rejected single write: strobe shows, then the device-fault code returns
        r = $urandom;
        wr_fail = 1'b1;
        q = {station, mbrtu_pkg::FN_WR_ONE, r[31:24], r[23:16], r[15:8], r[7:0]};
        e = {station, 8'h86, mbrtu_pkg::ERR_DEVICE};
        stb_exp = {r};
        run(seal(q), seal(e));
        wr_fail = 1'b0;
        // foreign station and a corrupted check field get no answer
        stb_exp.delete();
        e.delete();
        // station setting outside 1 to 32: even a matching address is not answered
        fn = station;
        station = 8'h21;
        run(seal({station, mbrtu_pkg::FN_WR_ONE, r[31:24], r[23:16], r[15:8], r[7:0]}), e);
        station = fn;
        q = {station ^ 8'h40, mbrtu_pkg::FN_WR_ONE, r[31:24], r[23:16], r[15:8], r[7:0]};
        run(seal(q), e);
        q = seal({station, mbrtu_pkg::FN_WR_ONE, r[31:24], r[23:16], r[15:8], r[7:0]});
        q[7] = q[7] ^ 8'h01;
        run(q, e);
        end_sim();
    end
endmodule : tb
bind mbrtu_write_slave mbrtu_write_slave_asserts #(.CLK_HZ(CLK_HZ)) chk (.I_CLK(I_CLK), .I_NRST(I_NRST),
    .I_RXD(I_RXD), .I_BAUD_SEL(I_BAUD_SEL), .I_STATION_ADDR(I_STATION_ADDR), .I_WR_FAIL(I_WR_FAIL),
    .O_TXD(O_TXD), .O_TX_EN(O_TX_EN), .O_WR_STB(O_WR_STB), .O_WR_OBJ(O_WR_OBJ), .O_WR_DATA(O_WR_DATA));
